// *** common/usbg_pkg.sv ***
// Package: register map, field positions and reset values for the status and baud block
package usbg_pkg;
    // ==========================================
    // Register addresses (three-bit select)
    localparam logic [2:0] ADDR_RXTX  = 3'h0;
    localparam logic [2:0] ADDR_IEN   = 3'h1;
    localparam logic [2:0] ADDR_LFMT  = 3'h3;
    localparam logic [2:0] ADDR_MCTL  = 3'h4;
    localparam logic [2:0] ADDR_LCF   = 3'h5;
    localparam logic [2:0] ADDR_MLF   = 3'h6;
    localparam logic [2:0] ADDR_SCR   = 3'h7;
    // ==========================================
    // Field positions
    localparam int LCF_AVAIL   = 0;
    localparam int LCF_OVR     = 1;
    localparam int LCF_PAR     = 2;
    localparam int LCF_STOP    = 3;
    localparam int LCF_BRK     = 4;
    localparam int LCF_THV     = 5;
    localparam int LCF_IDLE    = 6;
    localparam int LFMT_DIVSEL = 7;
    localparam int MCTL_LOOP   = 4;
    localparam int IEN_RXLINE  = 2;
    localparam int IEN_THV     = 1;
    localparam int IEN_MODEM   = 3;
    // ==========================================
    // Reset values
    localparam logic [7:0]  LFMT_RST = 8'h00;
    localparam logic [7:0]  MCTL_RST = 8'h00;
    localparam logic [7:0]  IEN_RST  = 8'h00;
    localparam logic [7:0]  SCR_RST  = 8'h00;
    localparam logic [15:0] DIV_RST  = 16'h0000;
    localparam int          DIV_W    = 16;
    // ==========================================
    // Clock rates: input clock may be up to 9 MHz
    localparam int OSC_MAX_KHZ = 9000;
endpackage : usbg_pkg

// *** hdl/usbg_status_baud.sv ***
// Line status, modem status, scratch and baud divider of a serial element
// Operation
// (RULE_01) Data-available bit 0 set on buffered character, cleared by buffer read.
// (RULE_02) Overrun bit 1 set when new character overwrites unread one.
// (RULE_03) Parity-mismatch bit 2 set on received parity disagreement.
// (RULE_04) Bad-stop bit 3 set when stop bit samples as zero.
// (RULE_05) Break bit 4 set when input low beyond one character time.
// (RULE_06) Reading line status clears bits 1 to 4.
// (RULE_07) Any of bits 1 to 4 sources receiver line status interrupt.
// (RULE_08) Holding-vacant bit 5 set on transfer, cleared on holding write.
// (RULE_09) Holding-vacant with its enable raises its interrupt.
// (RULE_10) Bit 6 high only when holding and shift registers empty.
// (RULE_11) Line status bit 7 reads zero.
// (RULE_12) Software treats line status as read-only outside factory test.
// (RULE_13) Change bits set on input change, all cleared by modem status read.
// (RULE_14) Bits 0,1,3 record any change of CTS, DSR, carrier.
// (RULE_15) Bit 2 set only on ring input rising from low to high.
// (RULE_16) Any change bit with enable raises the modem status interrupt.
// (RULE_17) Bits 4 to 7 return inverted CTS, DSR, ring, carrier.
// (RULE_18) In loopback, bits 4 to 7 follow control bits 1,0,2,3.
// (RULE_19) Eight-bit scratch register with no other effect.
// (RULE_20) Baud generator divides input clock by 1..65535 to 16x rate.
// (RULE_21) Divisor held in two byte latches, loaded at initialisation.
// (RULE_22) Writing either divisor byte reloads the baud counter at once.
// (RULE_23) Divisor latches reachable only with line format bit 7 set.
// (RULE_24) Line status interrupt highest, modem status lowest priority.
`timescale 1ns/1ps
`default_nettype none
module usbg_status_baud
    import usbg_pkg::*;
#(
    parameter int DivW = usbg_pkg::DIV_W
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // Processor register port
    input  wire logic [2:0]      regAddr,
    input  wire logic            rdStb,
    input  wire logic            wrStb,
    input  wire logic [7:0]      wrData,
    output logic [7:0]           rdData,
    // Receiver events, same clock
    input  wire logic            rxCharDone,
    input  wire logic            rxParityBad,
    input  wire logic            rxStopBad,
    input  wire logic            rxBreakSeen,
    // Transmitter events, same clock
    input  wire logic            txHoldToShift,
    input  wire logic            txShiftBusy,
    // Modem input pins, active low
    input  wire logic            ctsInB,
    input  wire logic            dsrInB,
    input  wire logic            ringInB,
    input  wire logic            carrierDetectInB,
    // Settings to the shift logic
    output logic [7:0]           lineFormat,
    output logic [7:0]           modemControl,
    output logic                 txHoldWrite,
    output logic                 rxBufRead,
    // Baud and interrupts
    output logic                 baudTick,
    output logic                 irqRxLine,
    output logic                 irqTxHold,
    output logic                 irqModem,
    output logic [1:0]           irqCode
);
    import usbg_pkg::*;

    // ==========================================
    // Reset release
    logic rstMeta_r;
    logic rstSync_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end
    wire logic rstN = rstSync_r;

    // ==========================================
    // Pin synchronisers; first stage read only by second
    logic [3:0] pinMeta_r;
    logic [3:0] pinSync_r;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta_r <= 4'hf;
            pinSync_r <= 4'hf;
        end else begin
            pinMeta_r <= {carrierDetectInB, ringInB, dsrInB, ctsInB};
            pinSync_r <= pinMeta_r;
        end
    end

    // ==========================================
    // Registers
    logic [7:0]      lfmt_r;
    logic [7:0]      mctl_r;
    logic [7:0]      ien_r;
    logic [7:0]      scr_r;
    logic [DivW-1:0] div_r;
    logic [DivW-1:0] baudCnt_r;
    logic            avail_r;
    logic [3:0]      err_r;
    logic            thv_r;
    logic [3:0]      delta_r;
    logic [3:0]      lvlPrev_r;

    // ==========================================
    // Decode
    wire logic divSel   = lfmt_r[LFMT_DIVSEL];
    wire logic hitRxTx  = (regAddr == ADDR_RXTX);
    wire logic hitIen   = (regAddr == ADDR_IEN);
    wire logic wrDivLo  = wrStb && hitRxTx && divSel; // RULE_23
    wire logic wrDivHi  = wrStb && hitIen && divSel; // RULE_23
    wire logic wrThr    = wrStb && hitRxTx && !divSel; // RULE_23
    wire logic wrIen    = wrStb && hitIen && !divSel;
    wire logic rdRbr    = rdStb && hitRxTx && !divSel;
    wire logic rdLcf    = rdStb && (regAddr == ADDR_LCF);
    wire logic rdMlf    = rdStb && (regAddr == ADDR_MLF);
    assign txHoldWrite  = wrThr;
    assign rxBufRead    = rdRbr;
    assign lineFormat   = lfmt_r;
    assign modemControl = mctl_r;

    // Modem levels, active high; loopback takes control bits 1,0,2,3
    wire logic       loopOn = mctl_r[MCTL_LOOP];
    wire logic [3:0] lvlPin = ~pinSync_r; // RULE_17
    wire logic [3:0] lvlLoop = {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]}; // RULE_18
    wire logic [3:0] lvlNow = loopOn ? lvlLoop : lvlPin;
    // Ring bit 2 fires when active level falls, i.e. pin rises
    wire logic [3:0] deltaEv = {lvlNow[3] ^ lvlPrev_r[3],
                                lvlPrev_r[2] & ~lvlNow[2],
                                lvlNow[1:0] ^ lvlPrev_r[1:0]}; // RULE_14 RULE_15

    // Error events in bit order 1..4
    wire logic       ovrEv = rxCharDone && avail_r && !rdRbr; // RULE_02
    wire logic [3:0] errEv = {rxBreakSeen, rxStopBad && rxCharDone,
                              rxParityBad && rxCharDone, ovrEv}; // RULE_03 RULE_04 RULE_05

    wire logic       txIdle = thv_r && !txShiftBusy; // RULE_10
    wire logic [7:0] lcfView = {1'b0, txIdle, thv_r, err_r, avail_r}; // RULE_11
    wire logic [7:0] mlfView = {lvlNow, delta_r};

    // ==========================================
    // Read mux
    always_comb begin
        case (regAddr)
            ADDR_RXTX: rdData = divSel ? div_r[7:0] : 8'h00;
            ADDR_IEN:  rdData = divSel ? div_r[15:8] : ien_r;
            ADDR_LFMT: rdData = lfmt_r;
            ADDR_MCTL: rdData = mctl_r;
            ADDR_LCF:  rdData = lcfView;
            ADDR_MLF:  rdData = mlfView;
            ADDR_SCR:  rdData = scr_r; // RULE_19
            default:   rdData = 8'h00;
        endcase
    end

    // ==========================================
    // Control registers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lfmt_r <= LFMT_RST;
            mctl_r <= MCTL_RST;
            ien_r  <= IEN_RST;
            scr_r  <= SCR_RST;
        end else begin
            if (wrStb && regAddr == ADDR_LFMT) lfmt_r <= wrData;
            if (wrStb && regAddr == ADDR_MCTL) mctl_r <= {3'h0, wrData[4:0]};
            if (wrIen) ien_r <= {4'h0, wrData[3:0]};
            if (wrStb && regAddr == ADDR_SCR) scr_r <= wrData; // RULE_19
        end
    end

    // ==========================================
    // Line status flags; a set in the same cycle beats the clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            avail_r <= 1'b0;
            err_r   <= 4'h0;
            thv_r   <= 1'b1;
        end else begin
            if (rxCharDone) avail_r <= 1'b1; // RULE_01
            else if (rdRbr) avail_r <= 1'b0; // RULE_01
            err_r <= (rdLcf ? 4'h0 : err_r) | errEv; // RULE_06
            if (txHoldToShift) thv_r <= 1'b1; // RULE_08
            else if (wrThr) thv_r <= 1'b0; // RULE_08
        end
    end
    // Factory-test writes to line status are ignored here; software keeps it read-only (RULE_12)

    // ==========================================
    // Modem change flags
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            delta_r   <= 4'h0;
            lvlPrev_r <= 4'h0;
        end else begin
            lvlPrev_r <= lvlNow;
            delta_r   <= (rdMlf ? 4'h0 : delta_r) | deltaEv; // RULE_13
        end
    end

    // ==========================================
    // Baud divider: a divisor of zero holds the tick off
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            div_r     <= DIV_RST;
            baudCnt_r <= DIV_RST;
            baudTick  <= 1'b0;
        end else begin
            baudTick <= 1'b0;
            if (wrDivLo || wrDivHi) begin
                div_r     <= wrDivLo ? {div_r[15:8], wrData} : {wrData, div_r[7:0]}; // RULE_21
                baudCnt_r <= wrDivLo ? {div_r[15:8], wrData} : {wrData, div_r[7:0]}; // RULE_22
            end else if (div_r != DIV_RST) begin
                if (baudCnt_r <= DivW'(1)) begin
                    baudCnt_r <= div_r; // RULE_20
                    baudTick  <= 1'b1; // RULE_20
                end else begin
                    baudCnt_r <= baudCnt_r - DivW'(1);
                end
            end
        end
    end

    // ==========================================
    // Interrupt sources and priority
    assign irqRxLine = ien_r[IEN_RXLINE] && (err_r != 4'h0); // RULE_07
    assign irqTxHold = ien_r[IEN_THV] && thv_r; // RULE_09
    assign irqModem  = ien_r[IEN_MODEM] && (delta_r != 4'h0); // RULE_16
    // 3 line, 2 data ready, 1 holding, 0 modem or none
    assign irqCode = irqRxLine ? 2'h3 :
                     (ien_r[0] && avail_r) ? 2'h2 :
                     irqTxHold ? 2'h1 : 2'h0; // RULE_24

    // ==========================================
    // Checks
    AST_AVAIL_SET: assert property (@(posedge clk) disable iff (!rstN)
        rxCharDone |=> avail_r) else $error("data available not set"); // RULE_01
    AST_OVR: assert property (@(posedge clk) disable iff (!rstN)
        ovrEv |=> err_r[0]) else $error("overrun lost"); // RULE_02
    AST_ERR_CLR: assert property (@(posedge clk) disable iff (!rstN)
        rdLcf && errEv == 4'h0 |=> err_r == 4'h0) else $error("errors not cleared"); // RULE_06
    AST_THV: assert property (@(posedge clk) disable iff (!rstN)
        wrThr && !txHoldToShift |=> !thv_r) else $error("hold vacant not cleared"); // RULE_08
    AST_IDLE: assert property (@(posedge clk) disable iff (!rstN)
        txShiftBusy |-> !lcfView[LCF_IDLE]) else $error("idle while busy"); // RULE_10
    AST_MLF_CLR: assert property (@(posedge clk) disable iff (!rstN)
        rdMlf && deltaEv == 4'h0 |=> delta_r == 4'h0) else $error("changes not cleared"); // RULE_13
    AST_RING: assert property (@(posedge clk) disable iff (!rstN)
        $fell(lvlNow[2]) |=> delta_r[2]) else $error("ring edge lost"); // RULE_15
    AST_LOOP: assert property (@(posedge clk) disable iff (!rstN)
        loopOn |-> mlfView[7:4] == {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]})
        else $error("loopback map wrong"); // RULE_18
    sequence sDivLoad;
        wrDivLo && wrData == 8'h02 && div_r[15:8] == 8'h00;
    endsequence
    AST_BAUD: assert property (@(posedge clk) disable iff (!rstN)
        sDivLoad ##1 !(wrDivLo || wrDivHi) [*2] |=> baudTick) else $error("baud tick late"); // RULE_22

    // ==========================================
    // Receiver flag checks
    sequence sRxCharRead;
        rdRbr && !rxCharDone;
    endsequence
    AST_AVAIL_CLR: assert property (@(posedge clk) disable iff (!rstN)
        sRxCharRead |=> !avail_r)
        else $error("data available not cleared"); // RULE_01
    AST_OVR_NONE: assert property (@(posedge clk) disable iff (!rstN)
        rxCharDone && !avail_r && !err_r[0] |=> !err_r[0])
        else $error("false overrun"); // RULE_02
    AST_PAR: assert property (@(posedge clk) disable iff (!rstN)
        rxCharDone && rxParityBad |=> err_r[1])
        else $error("parity error lost"); // RULE_03
    AST_STOP: assert property (@(posedge clk) disable iff (!rstN)
        rxCharDone && rxStopBad |=> err_r[2])
        else $error("bad stop lost"); // RULE_04
    AST_BRK: assert property (@(posedge clk) disable iff (!rstN)
        rxBreakSeen |=> err_r[3])
        else $error("break lost"); // RULE_05
    AST_RXLINE_IRQ: assert property (@(posedge clk) disable iff (!rstN)
        irqRxLine |-> ien_r[IEN_RXLINE] && lcfView[4:1] != 4'h0)
        else $error("line interrupt without source"); // RULE_07
    AST_RXLINE_SRC: assert property (@(posedge clk) disable iff (!rstN)
        ien_r[IEN_RXLINE] && lcfView[LCF_OVR] |-> irqRxLine)
        else $error("line interrupt missing"); // RULE_07

    // ==========================================
    // Transmitter flag and line status bit 7 checks
    AST_THV_SET: assert property (@(posedge clk) disable iff (!rstN)
        txHoldToShift |=> thv_r)
        else $error("hold vacant not set"); // RULE_08
    AST_THV_IRQ: assert property (@(posedge clk) disable iff (!rstN)
        ien_r[IEN_THV] && lcfView[LCF_THV] |-> irqTxHold)
        else $error("hold interrupt missing"); // RULE_09
    AST_IDLE_SET: assert property (@(posedge clk) disable iff (!rstN)
        thv_r && !txShiftBusy |-> lcfView[LCF_IDLE])
        else $error("idle flag missing"); // RULE_10
    AST_BIT7: assert property (@(posedge clk) disable iff (!rstN)
        regAddr == ADDR_LCF |-> rdData[7] == 1'b0)
        else $error("line status bit 7 set"); // RULE_11

    // ==========================================
    // Modem status checks
    sequence sRingRiseRead;
        $rose(lvlNow[2]) && rdMlf;
    endsequence
    AST_CTS_CHG: assert property (@(posedge clk) disable iff (!rstN)
        $changed(lvlNow[0]) |=> delta_r[0])
        else $error("send change lost"); // RULE_14
    AST_DSR_CHG: assert property (@(posedge clk) disable iff (!rstN)
        $changed(lvlNow[1]) |=> delta_r[1])
        else $error("ready change lost"); // RULE_14
    AST_DCD_CHG: assert property (@(posedge clk) disable iff (!rstN)
        $changed(lvlNow[3]) |=> delta_r[3])
        else $error("carrier change lost"); // RULE_14
    AST_RING_RISE: assert property (@(posedge clk) disable iff (!rstN)
        sRingRiseRead |=> !delta_r[2])
        else $error("ring flag on leading edge"); // RULE_15
    AST_MOD_IRQ: assert property (@(posedge clk) disable iff (!rstN)
        ien_r[IEN_MODEM] && mlfView[3:0] != 4'h0 |-> irqModem)
        else $error("modem interrupt missing"); // RULE_16
    AST_LEVELS: assert property (@(posedge clk) disable iff (!rstN)
        !loopOn |-> mlfView[7:4] == ~pinSync_r)
        else $error("modem levels wrong"); // RULE_17

    // ==========================================
    // Scratch, divider and priority checks
    AST_SCR: assert property (@(posedge clk) disable iff (!rstN)
        wrStb && regAddr == ADDR_SCR |=> scr_r == $past(wrData))
        else $error("scratch not written"); // RULE_19
    AST_BAUD_OFF: assert property (@(posedge clk) disable iff (!rstN)
        $past(div_r) == DIV_RST |-> !baudTick)
        else $error("tick with zero divisor"); // RULE_20
    AST_DIV_HI: assert property (@(posedge clk) disable iff (!rstN)
        wrDivHi |=> div_r[15:8] == $past(wrData))
        else $error("divisor high not written"); // RULE_21
    AST_DIV_LOCK: assert property (@(posedge clk) disable iff (!rstN)
        wrStb && !divSel |=> $stable(div_r))
        else $error("divisor written without access"); // RULE_23
    AST_PRIO: assert property (@(posedge clk) disable iff (!rstN)
        irqRxLine |-> irqCode == 2'h3)
        else $error("line interrupt not first"); // RULE_24
endmodule : usbg_status_baud
`default_nettype wire

// *** tb/usbg_modem_model.sv ***
// Modem side model driving the active-low status pins
`timescale 1ns/1ps
`default_nettype none
module usbg_modem_model (
    // Requested line states, high means asserted
    input  wire logic ctsOn,
    input  wire logic dsrOn,
    input  wire logic ringOn,
    input  wire logic dcdOn,
    // Pins toward the block, active low
    output logic      ctsInB,
    output logic      dsrInB,
    output logic      ringInB,
    output logic      carrierDetectInB
);
    // ==========================================
    // Pins idle high so an idle modem shows no change
    assign ctsInB           = ~ctsOn;
    assign dsrInB           = ~dsrOn;
    assign ringInB          = ~ringOn;
    assign carrierDetectInB = ~dcdOn;
endmodule : usbg_modem_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Register level testbench for the status and baud block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import usbg_pkg::*;
    logic       clk, rst_b, rdStb, wrStb, txShiftBusy, ctsOn, dsrOn, ringOn, dcdOn;
    logic       ctsInB, dsrInB, ringInB, carrierDetectInB, baudTick;
    logic       irqRxLine, irqTxHold, irqModem, txHoldWrite, rxBufRead;
    logic [2:0] regAddr;
    logic [4:0] ev;
    logic [7:0] wrData, rdData, rv, lineFormat, modemControl;
    logic [1:0] irqCode;
    int         errCount, nTests, n;
    usbg_status_baud uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .rdStb(rdStb), .wrStb(wrStb),
        .wrData(wrData), .rdData(rdData), .rxCharDone(ev[0]), .rxParityBad(ev[1]), .rxStopBad(ev[2]),
        .rxBreakSeen(ev[3]), .txHoldToShift(ev[4]), .txShiftBusy(txShiftBusy), .ctsInB(ctsInB),
        .dsrInB(dsrInB), .ringInB(ringInB), .carrierDetectInB(carrierDetectInB), .lineFormat(lineFormat),
        .modemControl(modemControl), .txHoldWrite(txHoldWrite), .rxBufRead(rxBufRead), .baudTick(baudTick),
        .irqRxLine(irqRxLine), .irqTxHold(irqTxHold), .irqModem(irqModem), .irqCode(irqCode));
    usbg_modem_model modem (.ctsOn(ctsOn), .dsrOn(dsrOn), .ringOn(ringOn), .dcdOn(dcdOn), .ctsInB(ctsInB),
        .dsrInB(dsrInB), .ringInB(ringInB), .carrierDetectInB(carrierDetectInB));
    // ==========================================
    // Clock and access tasks, all entered 1 ns after a rising edge
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [7:0] d);
        regAddr = a; wrData = d; wrStb = 1'b1;
        @(posedge clk); #1 wrStb = 1'b0;
        // Idle edge so a following call never re-raises the strobe at once
        @(posedge clk); #1;
    endtask : wr
    // Read data is sampled mid-cycle, before the clearing edge
    task rd(input logic [2:0] a, output logic [7:0] d);
        regAddr = a; rdStb = 1'b1;
        @(negedge clk) d = rdData;
        @(posedge clk); #1 rdStb = 1'b0;
        @(posedge clk); #1;
    endtask : rd
    task rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk(what, rv, exp);
    endtask : rchk
    task pulse(input logic [4:0] e);
        ev = e;
        @(posedge clk); #1 ev = 5'h00;
        @(posedge clk); #1;
    endtask : pulse
    // Bounded wait for the next baud tick, edges counted in n
    task waitTick;
        n = 0;
        do begin
            @(posedge clk); #1 n++;
        end while (baudTick !== 1'b1 && n < 200);
    endtask : waitTick
    task end_sim;
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    // ==========================================
    // Watchdog, far beyond the few hundred ns the tests take
    initial begin
        #40000;
        errCount++;
        end_sim();
    end
    initial begin
        {rst_b, rdStb, wrStb, txShiftBusy, ctsOn, dsrOn, ringOn, dcdOn} = '0;
        regAddr = 3'h0; wrData = 8'h00; ev = 5'h00; errCount = 0; nTests = 0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rchk("lcf reset", ADDR_LCF, 8'h60);
        rchk("mlf reset", ADDR_MLF, 8'h00);
        chk("irq reset", {6'h0, irqCode}, 8'h00);
        wr(ADDR_SCR, 8'ha5);
        wr(ADDR_LCF, 8'hff);
        rchk("scratch", ADDR_SCR, 8'ha5);
        rchk("lcf write ignored", ADDR_LCF, 8'h60);
        $display("test reset and scratch done");
        wr(ADDR_IEN, 8'h0f);
        pulse(5'h01);
        rchk("lcf ready", ADDR_LCF, 8'h61);
        chk("code data", {6'h0, irqCode}, 8'h02);
        pulse(5'h07);
        pulse(5'h08);
        chk("irq line", {7'h0, irqRxLine}, 8'h01);
        chk("code line", {6'h0, irqCode}, 8'h03);
        rchk("lcf errors", ADDR_LCF, 8'h7f);
        rchk("lcf cleared", ADDR_LCF, 8'h61);
        chk("irq line off", {7'h0, irqRxLine}, 8'h00);
        rd(ADDR_RXTX, rv);
        rchk("lcf buffer read", ADDR_LCF, 8'h60);
        chk("code hold", {6'h0, irqCode}, 8'h01);
        $display("test receive flags done");
        wr(ADDR_RXTX, 8'h55);
        rchk("lcf holding full", ADDR_LCF, 8'h00);
        chk("irq hold off", {7'h0, irqTxHold}, 8'h00);
        txShiftBusy = 1'b1;
        pulse(5'h10);
        rchk("lcf shift busy", ADDR_LCF, 8'h20);
        chk("irq hold on", {7'h0, irqTxHold}, 8'h01);
        txShiftBusy = 1'b0;
        rchk("lcf idle", ADDR_LCF, 8'h60);
        $display("test transmit flags done");
        wr(ADDR_IEN, 8'h08);
        {ctsOn, dsrOn, dcdOn} = 3'h7;
        repeat (6) @(posedge clk);
        #1 chk("irq modem", {7'h0, irqModem}, 8'h01);
        rchk("mlf change", ADDR_MLF, 8'hbb);
        rchk("mlf cleared", ADDR_MLF, 8'hb0);
        ringOn = 1'b1;
        repeat (6) @(posedge clk);
        #1 rchk("mlf ring on", ADDR_MLF, 8'hf0);
        ringOn = 1'b0;
        repeat (6) @(posedge clk);
        #1 rchk("mlf ring off", ADDR_MLF, 8'hb4);
        {ctsOn, dsrOn, dcdOn} = 3'h0;
        repeat (6) @(posedge clk);
        #1 rchk("mlf release", ADDR_MLF, 8'h0b);
        wr(ADDR_MCTL, 8'h12);
        rd(ADDR_MLF, rv);
        chk("loop rts", {4'h0, rv[7:4]}, 8'h01);
        wr(ADDR_MCTL, 8'h19);
        rd(ADDR_MLF, rv);
        chk("loop dtr out2", {4'h0, rv[7:4]}, 8'h0a);
        $display("test modem status done");
        wr(ADDR_LFMT, 8'h80);
        wr(ADDR_IEN, 8'h00);
        wr(ADDR_RXTX, 8'h05);
        waitTick();
        waitTick();
        chk("period five", 8'(n), 8'h05);
        wr(ADDR_RXTX, 8'h03);
        waitTick();
        // Write edge plus three edges; the write's idle edge is the first of them
        chk("reload first", 8'(n), 8'h02);
        waitTick();
        chk("period three", 8'(n), 8'h03);
        rchk("divisor low", ADDR_RXTX, 8'h03);
        rchk("divisor high", ADDR_IEN, 8'h00);
        chk("format out", lineFormat, 8'h80);
        chk("control out", modemControl, 8'h19);
        wr(ADDR_RXTX, 8'h02);
        waitTick();
        chk("reload two", 8'(n), 8'h01);
        waitTick();
        chk("period two", 8'(n), 8'h02);
        $display("test baud divider done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
